// File: hdl/xfer_branch_pkg.sv
// Purpose: constants and types for the transfer/boolean/branch opcode decoder
// Assumes: opcodes arrive as 8-bit bytes from program memory
// Notes: cycle counts are system clock cycles
//
// What this block does
// - eight-code register blocks take the register number from opcode bits 2:0
// - absolute jump/call use opcode bits 7:5 as address bits 10:8
// - load accumulator from direct, indirect, immediate: listed opcodes, two cycles
// - move to register: two cycles from accumulator/immediate, four from direct
// - move to direct: two from accumulator, else four; direct-to-direct three bytes
// - indirect writes: two cycles from accumulator/immediate, four from direct
// - load data pointer immediate: three bytes, four cycles
// - code reads at accumulator plus data pointer or program counter: one byte, four cycles
// - external data via indirect register or data pointer: one byte, four cycles
// - push and pop of a direct byte: two bytes, four cycles
// - exchanges with accumulator, including low-nibble exchange, take two cycles
// - and/or of direct bit or its inverse into carry: two bytes, four cycles
// - bit into carry two cycles, carry into bit four cycles
// - long call three bytes; long call, return, interrupt return four cycles
// - long jump, short jump, indirect jump each four cycles
// - carry/zero conditional relative jumps: two bytes, four cycles, taken or not
// - bit jumps three bytes four cycles; jump-and-clear clears bit on branch
// - compare-and-jump-if-not-equal forms: three bytes, four cycles
// - decrement-and-jump: two bytes register form, three bytes direct form, four cycles
// - every instruction is one to three bytes and one to eight cycles

package xfer_branch_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam logic [3:0] CYC_SHORT = 4'h2;
  localparam logic [3:0] CYC_LONG = 4'h4;
  localparam logic [3:0] CYC_MAX = 4'h8;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int REG_NUM_LSB = 0;
  localparam int REG_NUM_MSB = 2;
  localparam int PAGE_LSB = 5;
  localparam int PAGE_MSB = 7;
  localparam int IND_SEL_BIT = 0;
  localparam logic [4:0] ABS_LOW_PATTERN = 5'h01;
  localparam logic [4:0] ABS_CALL_PATTERN = 5'h11;

  // ------------------------------------------------------------
  // operation classes
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP, OP_MOV_A_REG, OP_MOV_A_DIR, OP_MOV_A_IND, OP_MOV_A_IMM,
    OP_MOV_REG_A, OP_MOV_REG_DIR, OP_MOV_REG_IMM,
    OP_MOV_DIR_A, OP_MOV_DIR_REG, OP_MOV_DIR_DIR, OP_MOV_DIR_IND,
    OP_MOV_DIR_IMM, OP_MOV_IND_A, OP_MOV_IND_DIR, OP_MOV_IND_IMM,
    OP_MOV_DP_IMM, OP_MOVC_DP, OP_MOVC_PC,
    OP_MOVX_RD_IND, OP_MOVX_RD_DP, OP_MOVX_WR_IND, OP_MOVX_WR_DP,
    OP_PUSH, OP_POP, OP_XCH_REG, OP_XCH_DIR, OP_XCH_IND, OP_XCHD,
    OP_CLR_C, OP_CLR_BIT, OP_SET_C, OP_SET_BIT, OP_CPL_C, OP_CPL_BIT,
    OP_ANL_C_BIT, OP_ANL_C_NBIT, OP_ORL_C_BIT, OP_ORL_C_NBIT,
    OP_MOV_C_BIT, OP_MOV_BIT_C,
    OP_ACALL, OP_LCALL, OP_RET, OP_RETI, OP_AJMP, OP_LJMP, OP_SJMP,
    OP_JC, OP_JNC, OP_JB, OP_JNB, OP_JBC, OP_JMP_IND, OP_JZ, OP_JNZ,
    OP_CJNE_A_DIR, OP_CJNE_A_IMM, OP_CJNE_REG, OP_CJNE_IND,
    OP_DJNZ_REG, OP_DJNZ_DIR
  } op_t;

  // decoded instruction handed to the datapath
  typedef struct packed {
    op_t op;
    logic [1:0] length;
    logic [3:0] cycles;
    logic [2:0] bank_working_register;
    logic indirect_pointer_register;
    logic [2:0] page_bits;
    logic clear_bit_on_branch;
    logic foreign;
  } decode_t;

endpackage : xfer_branch_pkg

// File: hdl/opcode_table.sv
// Purpose: combinational opcode to operation, length and cycle table
// Assumes: opcode is a stable byte from the same clock domain
// Notes: unlisted codes report foreign and decode as no-operation
`timescale 1ns/100ps
`default_nettype none

module opcode_table
(
  // opcode in
  input wire logic [7:0] opcode,
  // decoded out
  output xfer_branch_pkg::decode_t dec
);

  wire logic [4:0] low5 = opcode[4:0];
  wire logic [7:0] blk8 = {opcode[7:3], 3'h0};
  wire logic [7:0] blk2 = {opcode[7:1], 1'h0};
  wire logic is_abs = (low5 == xfer_branch_pkg::ABS_LOW_PATTERN)
    || (low5 == xfer_branch_pkg::ABS_CALL_PATTERN);

  xfer_branch_pkg::op_t op;
  logic [1:0] len;
  logic [3:0] cyc;
  logic hit;

  // classification of one opcode
  always_comb
  begin
    op = xfer_branch_pkg::OP_NOP;
    len = xfer_branch_pkg::LEN_ONE;
    cyc = xfer_branch_pkg::CYC_SHORT;
    hit = 1'b1;
    if (is_abs)
    begin
      op = low5[4] ? xfer_branch_pkg::OP_ACALL : xfer_branch_pkg::OP_AJMP;
      len = xfer_branch_pkg::LEN_TWO;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk8 == 8'hE8)
      op = xfer_branch_pkg::OP_MOV_A_REG;
    else if (blk8 == 8'hF8)
      op = xfer_branch_pkg::OP_MOV_REG_A;
    else if (blk8 == 8'hA8)
    begin
      op = xfer_branch_pkg::OP_MOV_REG_DIR;
      len = xfer_branch_pkg::LEN_TWO;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk8 == 8'h78)
    begin
      op = xfer_branch_pkg::OP_MOV_REG_IMM;
      len = xfer_branch_pkg::LEN_TWO;
    end
    else if (blk8 == 8'h88)
    begin
      op = xfer_branch_pkg::OP_MOV_DIR_REG;
      len = xfer_branch_pkg::LEN_TWO;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk8 == 8'hC8)
      op = xfer_branch_pkg::OP_XCH_REG;
    else if (blk8 == 8'hB8)
    begin
      op = xfer_branch_pkg::OP_CJNE_REG;
      len = xfer_branch_pkg::LEN_THREE;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk8 == 8'hD8)
    begin
      op = xfer_branch_pkg::OP_DJNZ_REG;
      len = xfer_branch_pkg::LEN_TWO;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk2 == 8'hE6)
      op = xfer_branch_pkg::OP_MOV_A_IND;
    else if (blk2 == 8'hF6)
      op = xfer_branch_pkg::OP_MOV_IND_A;
    else if (blk2 == 8'hA6)
    begin
      op = xfer_branch_pkg::OP_MOV_IND_DIR;
      len = xfer_branch_pkg::LEN_TWO;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk2 == 8'h76)
    begin
      op = xfer_branch_pkg::OP_MOV_IND_IMM;
      len = xfer_branch_pkg::LEN_TWO;
    end
    else if (blk2 == 8'h86)
    begin
      op = xfer_branch_pkg::OP_MOV_DIR_IND;
      len = xfer_branch_pkg::LEN_TWO;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk2 == 8'hE2)
    begin
      op = xfer_branch_pkg::OP_MOVX_RD_IND;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk2 == 8'hF2)
    begin
      op = xfer_branch_pkg::OP_MOVX_WR_IND;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else if (blk2 == 8'hC6)
      op = xfer_branch_pkg::OP_XCH_IND;
    else if (blk2 == 8'hD6)
      op = xfer_branch_pkg::OP_XCHD;
    else if (blk2 == 8'hB6)
    begin
      op = xfer_branch_pkg::OP_CJNE_IND;
      len = xfer_branch_pkg::LEN_THREE;
      cyc = xfer_branch_pkg::CYC_LONG;
    end
    else
    begin
      case (opcode)
        8'h00: op = xfer_branch_pkg::OP_NOP;
        8'hE5:
        begin
          op = xfer_branch_pkg::OP_MOV_A_DIR;
          len = xfer_branch_pkg::LEN_TWO;
        end
        8'h74:
        begin
          op = xfer_branch_pkg::OP_MOV_A_IMM;
          len = xfer_branch_pkg::LEN_TWO;
        end
        8'hF5:
        begin
          op = xfer_branch_pkg::OP_MOV_DIR_A;
          len = xfer_branch_pkg::LEN_TWO;
        end
        8'h85:
        begin
          op = xfer_branch_pkg::OP_MOV_DIR_DIR;
          len = xfer_branch_pkg::LEN_THREE;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h75:
        begin
          op = xfer_branch_pkg::OP_MOV_DIR_IMM;
          len = xfer_branch_pkg::LEN_THREE;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h90:
        begin
          op = xfer_branch_pkg::OP_MOV_DP_IMM;
          len = xfer_branch_pkg::LEN_THREE;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h93:
        begin
          op = xfer_branch_pkg::OP_MOVC_DP;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h83:
        begin
          op = xfer_branch_pkg::OP_MOVC_PC;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'hE0:
        begin
          op = xfer_branch_pkg::OP_MOVX_RD_DP;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'hF0:
        begin
          op = xfer_branch_pkg::OP_MOVX_WR_DP;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'hC0:
        begin
          op = xfer_branch_pkg::OP_PUSH;
          len = xfer_branch_pkg::LEN_TWO;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'hD0:
        begin
          op = xfer_branch_pkg::OP_POP;
          len = xfer_branch_pkg::LEN_TWO;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'hC5:
        begin
          op = xfer_branch_pkg::OP_XCH_DIR;
          len = xfer_branch_pkg::LEN_TWO;
        end
        8'hC3: op = xfer_branch_pkg::OP_CLR_C;
        8'hD3: op = xfer_branch_pkg::OP_SET_C;
        8'hB3: op = xfer_branch_pkg::OP_CPL_C;
        8'hC2:
        begin
          op = xfer_branch_pkg::OP_CLR_BIT;
          len = xfer_branch_pkg::LEN_TWO;
        end
        8'hD2:
        begin
          op = xfer_branch_pkg::OP_SET_BIT;
          len = xfer_branch_pkg::LEN_TWO;
        end
        8'hB2:
        begin
          op = xfer_branch_pkg::OP_CPL_BIT;
          len = xfer_branch_pkg::LEN_TWO;
        end
        8'h82, 8'hB0, 8'h72, 8'hA0:
        begin
          op = (opcode == 8'h82) ? xfer_branch_pkg::OP_ANL_C_BIT
            : (opcode == 8'hB0) ? xfer_branch_pkg::OP_ANL_C_NBIT
            : (opcode == 8'h72) ? xfer_branch_pkg::OP_ORL_C_BIT
            : xfer_branch_pkg::OP_ORL_C_NBIT;
          len = xfer_branch_pkg::LEN_TWO;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'hA2:
        begin
          op = xfer_branch_pkg::OP_MOV_C_BIT;
          len = xfer_branch_pkg::LEN_TWO;
        end
        8'h92:
        begin
          op = xfer_branch_pkg::OP_MOV_BIT_C;
          len = xfer_branch_pkg::LEN_TWO;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h12, 8'h02:
        begin
          op = opcode[4] ? xfer_branch_pkg::OP_LCALL
            : xfer_branch_pkg::OP_LJMP;
          len = xfer_branch_pkg::LEN_THREE;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h22, 8'h32:
        begin
          op = opcode[4] ? xfer_branch_pkg::OP_RETI
            : xfer_branch_pkg::OP_RET;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h73:
        begin
          op = xfer_branch_pkg::OP_JMP_IND;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h80, 8'h40, 8'h50, 8'h60, 8'h70:
        begin
          op = (opcode == 8'h80) ? xfer_branch_pkg::OP_SJMP
            : (opcode == 8'h40) ? xfer_branch_pkg::OP_JC
            : (opcode == 8'h50) ? xfer_branch_pkg::OP_JNC
            : (opcode == 8'h60) ? xfer_branch_pkg::OP_JZ
            : xfer_branch_pkg::OP_JNZ;
          len = xfer_branch_pkg::LEN_TWO;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'h20, 8'h30, 8'h10:
        begin
          op = (opcode == 8'h20) ? xfer_branch_pkg::OP_JB
            : (opcode == 8'h30) ? xfer_branch_pkg::OP_JNB
            : xfer_branch_pkg::OP_JBC;
          len = xfer_branch_pkg::LEN_THREE;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'hB5, 8'hB4:
        begin
          op = opcode[0] ? xfer_branch_pkg::OP_CJNE_A_DIR
            : xfer_branch_pkg::OP_CJNE_A_IMM;
          len = xfer_branch_pkg::LEN_THREE;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        8'hD5:
        begin
          op = xfer_branch_pkg::OP_DJNZ_DIR;
          len = xfer_branch_pkg::LEN_THREE;
          cyc = xfer_branch_pkg::CYC_LONG;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // field extraction is unconditional; datapath qualifies by op
  assign dec.op = op;
  assign dec.length = len;
  assign dec.cycles = cyc;
  assign dec.bank_working_register =
    opcode[xfer_branch_pkg::REG_NUM_MSB:xfer_branch_pkg::REG_NUM_LSB];
  assign dec.indirect_pointer_register = opcode[xfer_branch_pkg::IND_SEL_BIT];
  assign dec.page_bits =
    opcode[xfer_branch_pkg::PAGE_MSB:xfer_branch_pkg::PAGE_LSB];
  assign dec.clear_bit_on_branch =
    (op == xfer_branch_pkg::OP_JBC);
  assign dec.foreign = ~hit;

endmodule : opcode_table

`default_nettype wire

// File: hdl/xfer_branch_decoder.sv
// Purpose: registered decoder and cycle timer for transfer/boolean/branch ops
// Assumes: opcode_valid pulses once per instruction start, same clock
// Notes: foreign opcodes give a two-cycle one-byte no-operation
`timescale 1ns/100ps
`default_nettype none

module xfer_branch_decoder
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // program memory side
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  // datapath side
  input wire logic branch_taken,
  output xfer_branch_pkg::decode_t dec_q,
  output logic [10:0] abs_target_q,
  output logic [15:0] imm16_q,
  output logic clear_tested_bit,
  output logic busy,
  output logic done
);

  xfer_branch_pkg::decode_t dec_raw;
  xfer_branch_pkg::decode_t dec_fix;
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic accept;

  opcode_table u_table
  (
    .opcode(opcode),
    .dec(dec_raw)
  );

  // foreign opcodes collapse to a safe no-operation
  always_comb
  begin
    dec_fix = dec_raw;
    if (dec_raw.foreign)
    begin
      dec_fix.op = xfer_branch_pkg::OP_NOP;
      dec_fix.length = xfer_branch_pkg::LEN_ONE;
      dec_fix.cycles = xfer_branch_pkg::CYC_SHORT;
    end
  end

  assign accept = opcode_valid && !busy;
  assign busy = (count_q != 4'h0);
  // timing is fixed per opcode, so taken and not taken finish alike
  assign done = (count_q == 4'h1);
  assign count_d = accept ? dec_fix.cycles : (busy ? count_q - 4'h1 : 4'h0);
  assign clear_tested_bit = done && dec_q.clear_bit_on_branch
    && branch_taken;

  // ------------------------------------------------------------
  // cycle counter and decode register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      count_q <= 4'h0;
      dec_q <= '0;
      abs_target_q <= 11'h000;
      imm16_q <= 16'h0000;
    end
    else
    begin
      count_q <= count_d;
      if (accept)
      begin
        dec_q <= dec_fix;
        abs_target_q <= {dec_fix.page_bits, operand1};
        imm16_q <= {operand1, operand2};
      end
    end
  end

endmodule : xfer_branch_decoder

`default_nettype wire

// File: tb/xfer_branch_properties.sv
// Purpose: timing and field properties of the transfer/branch decoder
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto the decoder from the bench top
`timescale 1ns/100ps
`default_nettype none

module xfer_branch_properties
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // program memory side
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  // datapath side
  input wire logic branch_taken,
  input wire xfer_branch_pkg::decode_t dec_q,
  input wire logic [10:0] abs_target_q,
  input wire logic [15:0] imm16_q,
  input wire logic clear_tested_bit,
  input wire logic busy,
  input wire logic done
);
  wire take = opcode_valid && !busy;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  chk_reg_number:
    assert property (take && opcode[7:3] == 5'h1D |=>
      dec_q.bank_working_register == $past(opcode[2:0]))
    else $error("register number wrong");
  chk_abs_target:
    assert property (take && opcode[4:0] == 5'h01 |=>
      abs_target_q == {$past(opcode[7:5]), $past(operand1)})
    else $error("absolute target wrong");
  chk_call_page:
    assert property (take && opcode[4:0] == 5'h11 |=>
      dec_q.page_bits == $past(opcode[7:5]))
    else $error("call page bits wrong");
  chk_pointer_load:
    assert property (take && opcode == 8'h90 |=> dec_q.length == 2'h3
      && imm16_q == {$past(operand1), $past(operand2)})
    else $error("pointer immediate wrong");
  chk_short_done:
    assert property (take ##1 dec_q.cycles == 4'h2 |-> !done ##1 done)
    else $error("two-cycle timing wrong");
  chk_long_busy:
    assert property (take ##1 dec_q.cycles == 4'h4 |->
      (busy && !done)[*3] ##1 done)
    else $error("four-cycle timing wrong");
  chk_hold_refused:
    assert property (busy && !done |=> $stable(dec_q))
    else $error("decode changed while busy");
  chk_clear_pulse:
    assert property (take && opcode == 8'h10 |->
      ##4 (clear_tested_bit == branch_taken))
    else $error("clear pulse wrong");
  chk_clear_only_jbc:
    assert property (clear_tested_bit |->
      done && dec_q.op == xfer_branch_pkg::OP_JBC)
    else $error("clear pulse outside jump-and-clear");
  chk_cycle_range:
    assert property (busy |-> dec_q.cycles != 4'h0
      && dec_q.cycles <= xfer_branch_pkg::CYC_MAX
      && dec_q.length != 2'h0)
    else $error("length or cycle count out of range");
  chk_foreign_nop:
    assert property (dec_q.foreign |->
      dec_q.length == 2'h1 && dec_q.cycles == 4'h2)
    else $error("foreign opcode not a short no-op");
endmodule : xfer_branch_properties
`default_nettype wire

// File: tb/prog_mem_model.sv
// Purpose: program memory handing instruction bytes to the decoder
// Assumes: bench fills mem and pulses fetch with pc set
// Notes: slow adds three wait cycles; bytes are inverted once taken
`timescale 1ns/100ps
`default_nettype none

module prog_mem_model
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bench control
  input wire logic fetch,
  input wire logic [7:0] pc,
  input wire logic slow,
  // decoder side
  input wire logic busy,
  output logic [7:0] opcode,
  output logic [7:0] operand1,
  output logic [7:0] operand2,
  output logic opcode_valid
);
  logic [7:0] mem [0:255];
  logic pend_q = 1'b0;
  logic [1:0] wait_q = 2'h0;

  initial
  begin
    opcode = 8'h00;
    operand1 = 8'h00;
    operand2 = 8'h00;
    opcode_valid = 1'b0;
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      pend_q <= 1'b0;
      opcode_valid <= 1'b0;
    end
    else if (opcode_valid && !busy)
    begin
      // taken: stale bytes must not look valid
      opcode_valid <= 1'b0;
      opcode <= ~opcode;
      operand1 <= ~operand1;
      operand2 <= ~operand2;
    end
    else if (fetch && !pend_q)
    begin
      pend_q <= 1'b1;
      wait_q <= slow ? 2'h3 : 2'h0;
    end
    else if (pend_q && wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
    else if (pend_q)
    begin
      pend_q <= 1'b0;
      opcode_valid <= 1'b1;
      opcode <= mem[pc];
      operand1 <= mem[pc + 8'h01];
      operand2 <= mem[pc + 8'h02];
    end
  end
endmodule : prog_mem_model
`default_nettype wire

// File: tb/tb.sv
// Purpose: self-checking bench for the transfer/branch decoder
// Assumes: program memory model feeds the opcode side
// Notes: expectations come from the table below, not the design
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %0t got %0h expected %0h", $time, g, e); \
  end end

module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic fetch = 1'b0;
  logic slow = 1'b0;
  logic branch_taken = 1'b0;
  logic [7:0] pc = 8'h00;
  logic [7:0] opcode, operand1, operand2;
  logic opcode_valid, clear_tested_bit, busy, done;
  xfer_branch_pkg::decode_t dec_q;
  logic [10:0] abs_target_q;
  logic [15:0] imm16_q;
  int mismatches = 0;
  int comparisons = 0;
  int cycle_count = 0;
  // {opcode, foreign flag and length, cycles}
  logic [15:0] tbl [$] = {
    16'hE522, 16'hE612, 16'hE712, 16'h7422,
    16'hF812, 16'hFF12, 16'hA824, 16'hAF24, 16'h7822,
    16'hF522, 16'h8824, 16'h8534, 16'h8624, 16'h7534,
    16'hF612, 16'hA624, 16'h7722, 16'h9034, 16'h9314,
    16'h8314, 16'hE214, 16'hE314, 16'hE014, 16'hF014,
    16'hC024, 16'hD024, 16'hC812, 16'hC522, 16'hD612,
    16'h8224, 16'hB024, 16'h7224, 16'hA024, 16'hA222,
    16'h9224, 16'h1234, 16'h2214, 16'h3214, 16'h0234,
    16'h8024, 16'h7314, 16'h4024, 16'h5024, 16'h6024,
    16'h7024, 16'h3034, 16'hB534, 16'hB434, 16'hBF34,
    16'hB634, 16'hD824, 16'hDF24, 16'hD534, 16'h0012,
    16'h2892, 16'hA492, 16'hA592, 16'h8492, 16'hE492
  };

  always #10 ref_clk = ~ref_clk;

  prog_mem_model u_mem
  (
    .ref_clk(ref_clk), .reset(reset), .fetch(fetch), .pc(pc), .slow(slow),
    .busy(busy), .opcode(opcode), .operand1(operand1),
    .operand2(operand2), .opcode_valid(opcode_valid)
  );

  xfer_branch_decoder u_dut
  (
    .ref_clk(ref_clk), .reset(reset), .opcode(opcode),
    .opcode_valid(opcode_valid), .operand1(operand1), .operand2(operand2),
    .branch_taken(branch_taken), .dec_q(dec_q),
    .abs_target_q(abs_target_q), .imm16_q(imm16_q),
    .clear_tested_bit(clear_tested_bit), .busy(busy), .done(done)
  );

  task automatic load(input logic [7:0] a, b0, b1, b2);
    u_mem.mem[a] = b0;
    u_mem.mem[a + 8'h01] = b1;
    u_mem.mem[a + 8'h02] = b2;
  endtask : load

  task automatic request(input logic [7:0] a, b0, b1, b2, input logic s);
    load(a, b0, b1, b2);
    @(posedge ref_clk);
    pc <= a;
    slow <= s;
    fetch <= 1'b1;
    @(posedge ref_clk);
    fetch <= 1'b0;
  endtask : request

  // returns in the first cycle of the accepted instruction
  task automatic await(input logic chain, input logic [7:0] nxt,
    output int k);
    for (k = 0; k < 12 && !(opcode_valid === 1'b1 && busy === 1'b0); k++)
      @(posedge ref_clk);
    `CHK(k < 12, 1'b1)
    fetch <= chain;
    pc <= nxt;
    #1;
  endtask : await

  // returns in the done cycle
  task automatic finish(input logic [15:0] e);
    int k;
    k = 1;
    `CHK(dec_q.foreign, e[7])
    `CHK(dec_q.length, e[5:4])
    `CHK(dec_q.cycles, e[3:0])
    while (done !== 1'b1 && k < 10)
    begin
      @(posedge ref_clk);
      fetch <= 1'b0;
      #1;
      k++;
    end
    `CHK(4'(k), e[3:0])
  endtask : finish

  task automatic run(input logic [15:0] e, input logic [7:0] b1, b2,
    input logic s);
    int k;
    request(8'h40, e[15:8], b1, b2, s);
    await(1'b0, 8'h40, k);
    finish(e);
  endtask : run

  task automatic t_table;
    foreach (tbl[i])
    begin
      run(tbl[i], 8'h5A, 8'hC3, i[0]);
      if (tbl[i][7])
        `CHK(dec_q.op, xfer_branch_pkg::OP_NOP)
    end
  endtask : t_table

  task automatic t_fields;
    for (int r = 0; r < 8; r++)
    begin
      run({5'h1D, 3'(r), 8'h12}, 8'h00, 8'h00, 1'b0);
      `CHK(dec_q.bank_working_register, 3'(r))
      `CHK(dec_q.op, xfer_branch_pkg::OP_MOV_A_REG)
      run({3'(r), 5'h01, 8'h24}, 8'hA5, 8'h00, 1'b0);
      `CHK(abs_target_q, {3'(r), 8'hA5})
      `CHK(dec_q.op, xfer_branch_pkg::OP_AJMP)
      run({3'(r), 5'h11, 8'h24}, 8'h3C, 8'h00, 1'b1);
      `CHK(dec_q.op, xfer_branch_pkg::OP_ACALL)
      `CHK(dec_q.page_bits, 3'(r))
      `CHK(abs_target_q, {3'(r), 8'h3C})
    end
    run(16'hE712, 8'h00, 8'h00, 1'b0);
    `CHK(dec_q.indirect_pointer_register, 1'b1)
    `CHK(dec_q.op, xfer_branch_pkg::OP_MOV_A_IND)
    run(16'h9034, 8'hBE, 8'hEF, 1'b0);
    `CHK(imm16_q, 16'hBEEF)
    `CHK(dec_q.op, xfer_branch_pkg::OP_MOV_DP_IMM)
  endtask : t_fields

  task automatic t_jump_clear;
    for (int t = 0; t < 2; t++)
    begin
      @(posedge ref_clk);
      branch_taken <= t[0];
      run(16'h1034, 8'h20, 8'h05, 1'b0);
      `CHK(clear_tested_bit, t[0])
      `CHK(dec_q.op, xfer_branch_pkg::OP_JBC)
      run(16'h2034, 8'h20, 8'h05, 1'b1);
      `CHK(clear_tested_bit, 1'b0)
      `CHK(dec_q.op, xfer_branch_pkg::OP_JB)
    end
  endtask : t_jump_clear

  // second request waits, ignored, until the first has finished
  task automatic t_back_to_back;
    int k;
    load(8'h80, 8'hC3, 8'h00, 8'h00);
    request(8'h40, 8'h90, 8'h12, 8'h34, 1'b0);
    await(1'b1, 8'h80, k);
    finish(16'h9034);
    `CHK(imm16_q, 16'h1234)
    await(1'b0, 8'h80, k);
    `CHK(k, 2)
    finish(16'hC312);
  endtask : t_back_to_back

  task automatic t_reset;
    int k;
    request(8'h40, 8'h85, 8'h01, 8'h02, 1'b1);
    await(1'b0, 8'h40, k);
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    `CHK(busy, 1'b0)
    `CHK(done, 1'b0)
    `CHK(dec_q, '0)
    run(16'h0012, 8'h00, 8'h00, 1'b0);
  endtask : t_reset

  task automatic test_done;
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // hang guard, about eight times the expected run
  always @(posedge ref_clk)
  begin
    cycle_count++;
    if (cycle_count == 6000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_table();
    t_fields();
    t_jump_clear();
    t_back_to_back();
    t_reset();
    test_done();
  end
endmodule : tb

bind xfer_branch_decoder xfer_branch_properties u_chk
(
  .ref_clk(ref_clk), .reset(reset), .opcode(opcode),
  .opcode_valid(opcode_valid), .operand1(operand1), .operand2(operand2),
  .branch_taken(branch_taken), .dec_q(dec_q), .abs_target_q(abs_target_q),
  .imm16_q(imm16_q), .clear_tested_bit(clear_tested_bit), .busy(busy),
  .done(done)
);
`default_nettype wire
